// ---- asi_top.sv ----
// Asynchronous serial interface with AXI4-Lite register access
// Summary of operation
// - Word length 8 bits when length bit clear, 9 bits when set.
// - Output pin low during start bit, high during stop bit.
// - Idle character is a whole frame of ones without start bit.
// - Break control sends zero frames repeatedly, then one appended 1 bit.
// - Transmit LSB first; ninth bit comes from transmit ninth-bit control.
// - Data written while sending waits in holding buffer until frame ends.
// - Data written while idle starts at once and sets buffer-empty flag.
// - Buffer-empty interrupt when enabled; data waits while flag stays set.
// - Complete flag set after each frame; interrupts when enabled.
// - Status access then data write clears buffer-empty and complete flags.
// - Enabling transmitter sends idle frame first; re-enable drops buffer.
// - Receive LSB first; ninth received bit goes to receive ninth bit.
// - Completed character fills buffer, sets full flag, may interrupt.
// - Status access then data read clears full flag before next character.
// - Received break counts as framing error.
// - Idle frame detection sets idle flag and may interrupt.
// - Character while full sets overrun, keeps buffer, may interrupt.
// - Noise sets noise flag with full flag; cleared by status/data read.
// - Missing stop bit sets framing error; cleared by status/data read.
// - Rate is clock / 32 / prescaler / own power of two.
// - Muted receiver sets no status flags and raises no receive interrupts.
// - Mute wakes on idle frame when wake bit clear, on word with MSB set when set.
// - Enabled idle transmitter rests high; disabled returns pin to port.
// - Receiver disable clears receive flags; enable starts start-bit search.
`timescale 1ns/100ps
`include "asi_regs.svh"
`default_nettype none
module asi_top (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic CPU_IRQ_MASK,
	input wire logic SERIAL_IN_PIN,
	output logic TX_PIN,
	output logic TX_PIN_OE,
	output logic IRQ
);
	logic aw_got, w_got;
	logic [7:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane;
	logic [7:0] ctrl1, ctrl2, rate;
	logic status_seen;
	logic tx_buffer_empty_flag, tc, hold_full, pre_pend, last_brk, tx_on_d;
	logic [8:0] hold;
	logic [11:0] tx_shift;
	logic [3:0] tx_left, tx_sub;
	logic rx_full, idle_flag, overrun, noise_flag, fe, mute, rx9;
	logic [7:0] rx_buf;
	logic [11:0] tx_cnt, rx_cnt;
	logic tx_tick, rx_tick;
	asi_pkg::asi_rx_state_e rx_state;
	logic [3:0] rx_sub, rx_idx;
	logic [9:0] rx_shift;
	logic [1:0] votes;
	logic rx_noise, rx_fin, rx_line, idle_armed, idle_evt;
	logic [7:0] idle_cnt;
	logic wr_go, wr_data, wr_ctrl1, wr_ctrl2, wr_rate, rd_go;
	logic rd_status, rd_data, tx_on, rx_on, len9, frame_bit;
	logic [3:0] frame_len;
	logic [8:0] rx_word;
	logic [11:0] tx_per, rx_per;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic next_irq;

	function automatic logic [11:0] half_per(input logic [1:0] sel,
		input logic [2:0] ex);
		logic [11:0] p;
		case (sel)
			2'b00: p = `ASI_HALF_PR1;
			2'b01: p = `ASI_HALF_PR3;
			2'b10: p = `ASI_HALF_PR4;
			default: p = `ASI_HALF_PR13;
		endcase
		half_per = p << ex;
	endfunction

	assign tx_on = ctrl2[`ASI_C2_TXON];
	assign rx_on = ctrl2[`ASI_C2_RXON];
	assign len9 = ctrl1[`ASI_C1_LEN9];
	assign frame_len = len9 ? `ASI_FRAME9 : `ASI_FRAME8;
	assign wr_go = aw_got && w_got && !BVALID;
	assign wr_data = wr_go && aw_addr == `ASI_OFS_DATA && w_lane;
	assign wr_ctrl1 = wr_go && aw_addr == `ASI_OFS_CTRL1 && w_lane;
	assign wr_ctrl2 = wr_go && aw_addr == `ASI_OFS_CTRL2 && w_lane;
	assign wr_rate = wr_go && aw_addr == `ASI_OFS_RATE && w_lane;
	assign rd_go = ARVALID && ARREADY;
	assign rd_status = rd_go && ARADDR == `ASI_OFS_STATUS;
	assign rd_data = rd_go && ARADDR == `ASI_OFS_DATA;

	// Write address and data capture
	always_ff @(posedge MCLK) begin
		if (RST) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			AWREADY <= 1'b1;
			WREADY <= 1'b1;
			BVALID <= 1'b0;
			BRESP <= `ASI_RESP_OKAY;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got <= 1'b1;
				aw_addr <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_got <= 1'b1;
				w_byte <= WDATA[7:0];
				w_lane <= WSTRB[0];
				WREADY <= 1'b0;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				BVALID <= 1'b1;
				case (aw_addr)
					`ASI_OFS_STATUS, `ASI_OFS_DATA, `ASI_OFS_RATE,
					`ASI_OFS_CTRL1, `ASI_OFS_CTRL2: BRESP <= `ASI_RESP_OKAY;
					default: BRESP <= `ASI_RESP_SLVERR;
				endcase
			end
			if (BVALID && BREADY) begin
				BVALID <= 1'b0;
				AWREADY <= 1'b1;
				WREADY <= 1'b1;
			end
		end
	end

	// Read mux
	always_comb begin
		next_rdata = 32'h00000000;
		next_rresp = `ASI_RESP_OKAY;
		case (ARADDR)
			`ASI_OFS_STATUS: next_rdata[7:0] = {tx_buffer_empty_flag, tc, rx_full, idle_flag,
				overrun, noise_flag, fe, 1'b0};
			`ASI_OFS_DATA: next_rdata[7:0] = rx_buf;
			`ASI_OFS_RATE: next_rdata[7:0] = rate;
			`ASI_OFS_CTRL1: next_rdata[7:0] = {rx9, ctrl1[6:0]};
			`ASI_OFS_CTRL2: next_rdata[7:0] = {ctrl2[7:2], mute, ctrl2[0]};
			default: next_rresp = `ASI_RESP_SLVERR;
		endcase
	end

	// Read channel
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ARREADY <= 1'b1;
			RVALID <= 1'b0;
			RDATA <= 32'h00000000;
			RRESP <= `ASI_RESP_OKAY;
		end else if (rd_go) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b1;
			RDATA <= next_rdata;
			RRESP <= next_rresp;
		end else if (RVALID && RREADY) begin
			RVALID <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Control registers
	always_ff @(posedge MCLK) begin
		if (RST) begin
			ctrl1 <= `ASI_CTRL1_RST;
			ctrl2 <= `ASI_CTRL2_RST;
			rate <= `ASI_RATE_RST;
		end else begin
			if (wr_ctrl1)
				ctrl1 <= {1'b0, w_byte[6], 1'b0, w_byte[4:3], 3'b000};
			if (wr_ctrl2)
				ctrl2 <= w_byte;
			if (wr_rate)
				rate <= w_byte;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RST)
			status_seen <= 1'b0;
		else if (rd_status)
			status_seen <= 1'b1;
		else if (wr_data || rd_data)
			status_seen <= 1'b0;
	end

	assign tx_per = half_per(rate[`ASI_RATE_PR_HI:`ASI_RATE_PR_LO],
		rate[`ASI_RATE_TX_HI:`ASI_RATE_TX_LO]);
	assign rx_per = half_per(rate[`ASI_RATE_PR_HI:`ASI_RATE_PR_LO],
		rate[`ASI_RATE_RX_HI:`ASI_RATE_RX_LO]);
	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx_cnt <= 12'h000;
			rx_cnt <= 12'h000;
			tx_tick <= 1'b0;
			rx_tick <= 1'b0;
		end else begin
			tx_tick <= tx_cnt == tx_per - 12'h001;
			rx_tick <= rx_cnt == rx_per - 12'h001;
			tx_cnt <= (tx_cnt >= tx_per - 12'h001) ? 12'h000 : tx_cnt + 12'h001;
			rx_cnt <= (rx_cnt >= rx_per - 12'h001) ? 12'h000 : rx_cnt + 12'h001;
		end
	end

	// Transmitter and its flags
	always_ff @(posedge MCLK) begin
		if (RST) begin
			tx_buffer_empty_flag <= 1'b1;
			tc <= 1'b1;
			hold <= 9'h000;
			hold_full <= 1'b0;
			pre_pend <= 1'b0;
			last_brk <= 1'b0;
			tx_on_d <= 1'b0;
			tx_shift <= 12'hfff;
			tx_left <= 4'h0;
			tx_sub <= 4'h0;
		end else begin
			tx_on_d <= tx_on;
			if (wr_data) begin
				hold <= {ctrl1[`ASI_C1_TX9], w_byte};
				hold_full <= 1'b1;
				if (status_seen) begin
					tx_buffer_empty_flag <= 1'b0;
					tc <= 1'b0;
				end
			end
			if (tx_on && !tx_on_d) begin
				pre_pend <= 1'b1;
				hold_full <= 1'b0;
			end
			if (tx_left != 4'h0) begin
				if (tx_tick) begin
					tx_sub <= tx_sub + 4'h1;
					if (tx_sub == `ASI_OVS_LAST) begin
						tx_shift <= {1'b1, tx_shift[11:1]};
						tx_left <= tx_left - 4'h1;
						if (tx_left == 4'h1)
							tc <= 1'b1;
					end
				end
			end else if (tx_on && tx_on_d) begin
				tx_sub <= 4'h0;
				if (pre_pend) begin
					tx_shift <= 12'hfff;
					tx_left <= frame_len;
					pre_pend <= 1'b0;
				end else if (ctrl2[`ASI_C2_BRK]) begin
					tx_shift <= 12'h000;
					tx_left <= frame_len;
					last_brk <= 1'b1;
				end else if (last_brk) begin
					tx_shift <= 12'hfff;
					tx_left <= 4'h1;
					last_brk <= 1'b0;
				end else if (hold_full && !tx_buffer_empty_flag) begin
					tx_shift <= len9 ? {2'b11, hold, 1'b0}
						: {3'b111, hold[7:0], 1'b0};
					tx_left <= frame_len;
					hold_full <= 1'b0;
					tx_buffer_empty_flag <= 1'b1;
				end
			end
		end
	end

	// pin rests high, released when off
	always_ff @(posedge MCLK) begin
		if (RST) begin
			TX_PIN <= 1'b1;
			TX_PIN_OE <= 1'b0;
		end else begin
			TX_PIN <= (tx_left != 4'h0) ? tx_shift[0] : 1'b1;
			TX_PIN_OE <= tx_on;
		end
	end

	assign frame_bit = (votes + {1'b0, rx_line}) >= 2'd2;

	// Receiver shifter
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_line <= 1'b1;
			rx_state <= asi_pkg::ASI_RX_HUNT;
			rx_sub <= 4'h0;
			rx_idx <= 4'h0;
			rx_shift <= 10'h000;
			votes <= 2'b00;
			rx_noise <= 1'b0;
			rx_fin <= 1'b0;
			idle_cnt <= 8'h00;
			idle_armed <= 1'b1;
			idle_evt <= 1'b0;
		end else begin
			rx_line <= SERIAL_IN_PIN;
			rx_fin <= 1'b0;
			idle_evt <= 1'b0;
			if (!rx_on) begin
				rx_state <= asi_pkg::ASI_RX_HUNT;
				idle_cnt <= 8'h00;
				idle_armed <= 1'b1;
			end else if (rx_tick) begin
				case (rx_state)
					asi_pkg::ASI_RX_HUNT: begin
						rx_sub <= 4'h0;
						rx_idx <= 4'h0;
						votes <= 2'b00;
						rx_noise <= 1'b0;
						if (!rx_line) begin
							rx_state <= asi_pkg::ASI_RX_START;
							idle_cnt <= 8'h00;
						end else if (idle_cnt == {frame_len, 4'h0} - 8'h01) begin
							idle_evt <= idle_armed;
							idle_armed <= 1'b0;
						end else begin
							idle_cnt <= idle_cnt + 8'h01;
						end
					end
					asi_pkg::ASI_RX_START: begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == `ASI_OVS_MID && rx_line)
							rx_state <= asi_pkg::ASI_RX_HUNT;
						else if (rx_sub == `ASI_OVS_LAST)
							rx_state <= asi_pkg::ASI_RX_BITS;
					end
					asi_pkg::ASI_RX_BITS: begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == `ASI_OVS_MID - 4'h1 || rx_sub == `ASI_OVS_MID)
							votes <= votes + {1'b0, rx_line};
						if (rx_sub == `ASI_OVS_MID + 4'h1) begin
							rx_shift <= {frame_bit, rx_shift[9:1]};
							if (votes + {1'b0, rx_line} != 2'd0
								&& votes + {1'b0, rx_line} != 2'd3)
								rx_noise <= 1'b1;
						end
						if (rx_sub == `ASI_OVS_LAST) begin
							votes <= 2'b00;
							rx_idx <= rx_idx + 4'h1;
							if (rx_idx == frame_len - 4'h2) begin
								rx_state <= asi_pkg::ASI_RX_HUNT;
								rx_fin <= 1'b1;
								idle_armed <= 1'b1;
							end
						end
					end
					default: rx_state <= asi_pkg::ASI_RX_HUNT;
				endcase
			end
		end
	end

	assign rx_word = len9 ? rx_shift[8:0] : {1'b0, rx_shift[8:1]};

	// Receive flags and mute
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rx_full <= 1'b0;
			idle_flag <= 1'b0;
			overrun <= 1'b0;
			noise_flag <= 1'b0;
			fe <= 1'b0;
			mute <= 1'b0;
			rx9 <= 1'b0;
			rx_buf <= 8'h00;
		end else begin
			if (wr_ctrl2)
				mute <= w_byte[`ASI_C2_MUTE];
			if (rd_data && status_seen) begin
				rx_full <= 1'b0;
				idle_flag <= 1'b0;
				overrun <= 1'b0;
				noise_flag <= 1'b0;
				fe <= 1'b0;
			end
			if (!rx_on) begin
				rx_full <= 1'b0;
				idle_flag <= 1'b0;
				overrun <= 1'b0;
				noise_flag <= 1'b0;
				fe <= 1'b0;
			end else if (idle_evt) begin
				if (mute) begin
					if (!ctrl1[`ASI_C1_WAKE])
						mute <= 1'b0;
				end else begin
					idle_flag <= 1'b1;
				end
			end else if (rx_fin && (!mute
				|| (ctrl1[`ASI_C1_WAKE] && rx_shift[8]))) begin
				// muted word sets nothing unless it wakes
				mute <= 1'b0;
				if (rx_full) begin
					overrun <= 1'b1;
				end else begin
					rx_full <= 1'b1;
					rx_buf <= rx_word[7:0];
					rx9 <= rx_word[8];
					noise_flag <= rx_noise;
					fe <= !rx_shift[9];
				end
			end
		end
	end

	assign next_irq = !CPU_IRQ_MASK && ((tx_buffer_empty_flag && ctrl2[`ASI_C2_TXEIE])
		|| (tc && ctrl2[`ASI_C2_DONEIE])
		|| (!mute && (rx_full || overrun) && ctrl2[`ASI_C2_RXIE])
		|| (!mute && idle_flag && ctrl2[`ASI_C2_QUIETIE]));
	always_ff @(posedge MCLK) begin
		if (RST)
			IRQ <= 1'b0;
		else
			IRQ <= next_irq;
	end
endmodule // asi_top
`default_nettype wire

// ---- asi_regs.svh ----
// Register offsets, field positions, reset values and counts
`ifndef ASI_REGS_SVH
`define ASI_REGS_SVH
`define ASI_OFS_STATUS 8'h00
`define ASI_OFS_DATA 8'h04
`define ASI_OFS_RATE 8'h08
`define ASI_OFS_CTRL1 8'h0c
`define ASI_OFS_CTRL2 8'h10
`define ASI_ST_TXE 7
`define ASI_ST_TC 6
`define ASI_ST_RXF 5
`define ASI_ST_IDLE 4
`define ASI_ST_OVR 3
`define ASI_ST_NF 2
`define ASI_ST_FE 1
`define ASI_C1_RX9 7
`define ASI_C1_TX9 6
`define ASI_C1_LEN9 4
`define ASI_C1_WAKE 3
`define ASI_C2_TXEIE 7
`define ASI_C2_DONEIE 6
`define ASI_C2_RXIE 5
`define ASI_C2_QUIETIE 4
`define ASI_C2_TXON 3
`define ASI_C2_RXON 2
`define ASI_C2_MUTE 1
`define ASI_C2_BRK 0
`define ASI_RATE_PR_HI 7
`define ASI_RATE_PR_LO 6
`define ASI_RATE_TX_HI 5
`define ASI_RATE_TX_LO 3
`define ASI_RATE_RX_HI 2
`define ASI_RATE_RX_LO 0
`define ASI_CTRL1_RST 8'h00
`define ASI_CTRL2_RST 8'h00
`define ASI_RATE_RST 8'h00
`define ASI_HALF_PR1 12'h002
`define ASI_HALF_PR3 12'h006
`define ASI_HALF_PR4 12'h008
`define ASI_HALF_PR13 12'h01a
`define ASI_OVS_LAST 4'hf
`define ASI_OVS_MID 4'h8
`define ASI_FRAME8 4'ha
`define ASI_FRAME9 4'hb
`define ASI_RESP_OKAY 2'b00
`define ASI_RESP_SLVERR 2'b10
`endif

// ---- asi_pkg.sv ----
// Types shared by the serial interface
package asi_pkg;
	typedef enum logic [1:0] {
		ASI_RX_HUNT = 2'b00,
		ASI_RX_START = 2'b01,
		ASI_RX_BITS = 2'b10
	} asi_rx_state_e;
endpackage

// ---- asi_top_monitor.sv ----
// Bus and pin checks on the serial interface ports
`timescale 1ns/100ps
`include "asi_regs.svh"
`default_nettype none
module asi_monitor (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic [1:0] BRESP,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic CPU_IRQ_MASK,
	input wire logic TX_PIN,
	input wire logic TX_PIN_OE,
	input wire logic IRQ
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RST);
	logic [9:0] on_age;
	always_ff @(posedge MCLK) begin
		if (RST || !TX_PIN_OE)
			on_age <= 10'h000;
		else if (on_age != 10'h3ff)
			on_age <= on_age + 10'h001;
	end
	a_write_hold: assert property (BVALID && !BREADY
		|=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	a_read_hold: assert property (RVALID && !RREADY
		|=> RVALID && $stable(RDATA))
		else $error("read data dropped early");
	a_read_answer: assert property (ARVALID && ARREADY
		|=> RVALID && RDATA[31:8] == 24'h0)
		else $error("read answer late or wide");
	a_read_busy: assert property (RVALID |-> !ARREADY)
		else $error("read address taken while busy");
	a_write_busy: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write taken while busy");
	a_bad_addr: assert property (AWVALID && AWREADY && WVALID
		&& WREADY && AWADDR > 8'h10
		|-> ##2 BVALID && BRESP == `ASI_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_irq_masked: assert property (CPU_IRQ_MASK |=> !IRQ)
		else $error("interrupt while masked");
	a_idle_first: assert property ($fell(TX_PIN) && TX_PIN_OE
		|-> on_age >= 10'h12c)
		else $error("no idle frame after enable");
endmodule // asi_monitor
bind asi_top asi_monitor mon (.MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WVALID,
	.WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY, .RDATA, .RVALID,
	.RREADY, .CPU_IRQ_MASK, .TX_PIN, .TX_PIN_OE, .IRQ);
`default_nettype wire

// ---- asi_remote.sv ----
// Remote serial transceiver on the two-wire line
`timescale 1ns/100ps
`default_nettype none
module asi_remote (
	input wire logic MCLK,
	input wire logic TX_PIN,
	output var logic SERIAL_IN_PIN
);
	initial SERIAL_IN_PIN = 1'b1;
	int bit_len = 32;
	task send(input logic [8:0] d, input int n, input logic stp);
		int i;
		SERIAL_IN_PIN <= 1'b0;
		repeat (32) @(posedge MCLK);
		for (i = 0; i < n; i++) begin
			SERIAL_IN_PIN <= d[i];
			repeat (32) @(posedge MCLK);
		end
		SERIAL_IN_PIN <= stp;
		repeat (32) @(posedge MCLK);
		SERIAL_IN_PIN <= 1'b1;
		repeat (64) @(posedge MCLK);
	endtask
	task grab(input int n, output logic [8:0] w, output logic stp);
		int i;
		int k;
		k = 0;
		while (TX_PIN !== 1'b0 && k < 2000) begin
			@(posedge MCLK);
			k++;
		end
		repeat (bit_len / 2) @(posedge MCLK);
		w = 9'h0;
		for (i = 0; i < n; i++) begin
			repeat (bit_len) @(posedge MCLK);
			w[i] = TX_PIN;
		end
		repeat (bit_len) @(posedge MCLK);
		stp = TX_PIN;
	endtask
	// glitch across bit 0 centre samples
	task send_noisy(input logic [7:0] d);
		int i;
		SERIAL_IN_PIN <= 1'b0;
		repeat (32) @(posedge MCLK);
		SERIAL_IN_PIN <= d[0];
		repeat (10) @(posedge MCLK);
		SERIAL_IN_PIN <= !d[0];
		repeat (9) @(posedge MCLK);
		SERIAL_IN_PIN <= d[0];
		repeat (13) @(posedge MCLK);
		for (i = 1; i < 8; i++) begin
			SERIAL_IN_PIN <= d[i];
			repeat (32) @(posedge MCLK);
		end
		SERIAL_IN_PIN <= 1'b1;
		repeat (96) @(posedge MCLK);
	endtask
endmodule // asi_remote
`default_nettype wire

// ---- asi_top_tb_top.sv ----
// Testbench for the serial interface
`timescale 1ns/100ps
`include "asi_regs.svh"
`default_nettype none
module asi_top_tb_top;
	logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, CPU_IRQ_MASK;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_PIN, TX_PIN_OE, IRQ;
	logic SERIAL_IN_PIN;
	logic [7:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, r;
	logic [3:0] WSTRB;
	logic [1:0] BRESP, RRESP;
	logic [8:0] w;
	logic s;
	int fail_count, comparisons, cycles;
	asi_top uut (.MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
		.WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
		.RDATA, .RRESP, .RVALID, .RREADY, .CPU_IRQ_MASK, .SERIAL_IN_PIN,
		.TX_PIN, .TX_PIN_OE, .IRQ);
	asi_remote far (.MCLK, .TX_PIN, .SERIAL_IN_PIN);
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		AWADDR <= a;
		WDATA <= {24'h0, d};
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1 && n < 50);
		BREADY <= 1'b0;
		chk("bvalid", BVALID, 1);
		chk("bresp", BRESP, er);
	endtask
	task rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge MCLK);
			n++;
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1 && n < 50);
		r = RDATA;
		RREADY <= 1'b0;
		chk("rvalid", RVALID, 1);
		chk("rresp", RRESP, er);
	endtask
	task t_reset;
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("status", r, 32'hc0);
		rd(`ASI_OFS_CTRL2, 2'b00);
		chk("ctrl2", r, 32'h0);
		rd(8'h14, `ASI_RESP_SLVERR);
		chk("unmapped", r, 32'h0);
		wr(8'h14, 8'hff, `ASI_RESP_SLVERR);
	endtask
	task t_tx;
		wr(`ASI_OFS_CTRL2, 8'h08, 2'b00);
		repeat (400) @(posedge MCLK);
		fork
			far.grab(8, w, s);
			begin
				rd(`ASI_OFS_STATUS, 2'b00);
				wr(`ASI_OFS_DATA, 8'ha5, 2'b00);
				rd(`ASI_OFS_STATUS, 2'b00);
				chk("txe", r[`ASI_ST_TXE], 1);
				chk("tc", r[`ASI_ST_TC], 0);
				wr(`ASI_OFS_DATA, 8'h3c, 2'b00);
			end
		join
		chk("word1", w, 9'h0a5);
		chk("stop1", s, 1);
		far.grab(8, w, s);
		chk("word2", w, 9'h03c);
		repeat (40) @(posedge MCLK);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("tc_end", r[`ASI_ST_TC], 1);
		wr(`ASI_OFS_CTRL1, 8'h50, 2'b00);
		rd(`ASI_OFS_STATUS, 2'b00);
		wr(`ASI_OFS_DATA, 8'h3c, 2'b00);
		far.grab(9, w, s);
		chk("word9", w, 9'h13c);
		wr(`ASI_OFS_CTRL2, 8'h09, 2'b00);
		far.grab(9, w, s);
		chk("break", {w, s}, 10'h0);
		wr(`ASI_OFS_CTRL2, 8'h08, 2'b00);
		repeat (800) @(posedge MCLK);
		chk("after_break", TX_PIN, 1);
		wr(`ASI_OFS_CTRL1, 8'h00, 2'b00);
	endtask
	task t_rx;
		wr(`ASI_OFS_CTRL2, 8'h2c, 2'b00);
		CPU_IRQ_MASK <= 1'b0;
		far.send(9'h05a, 8, 1'b1);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("rxfull", r[`ASI_ST_RXF], 1);
		chk("irq", IRQ, 1);
		rd(`ASI_OFS_DATA, 2'b00);
		chk("rxdata", r, 32'h5a);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("rxfull_clr", r[`ASI_ST_RXF], 0);
		far.send(9'h011, 8, 1'b1);
		far.send(9'h022, 8, 1'b1);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("overrun", r[`ASI_ST_OVR], 1);
		rd(`ASI_OFS_DATA, 2'b00);
		chk("kept", r, 32'h11);
		far.send(9'h000, 8, 1'b0);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("framing", r[`ASI_ST_FE], 1);
		rd(`ASI_OFS_DATA, 2'b00);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("fe_clr", r[`ASI_ST_FE], 0);
		far.send_noisy(8'h5a);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("noise", r[`ASI_ST_NF], 1);
		chk("noise_full", r[`ASI_ST_RXF], 1);
		rd(`ASI_OFS_DATA, 2'b00);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("nf_clr", r[`ASI_ST_NF], 0);
	endtask
	task t_mute;
		wr(`ASI_OFS_CTRL1, 8'h08, 2'b00);
		wr(`ASI_OFS_CTRL2, 8'h0e, 2'b00);
		far.send(9'h033, 8, 1'b1);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("muted", r[`ASI_ST_RXF], 0);
		far.send(9'h080, 8, 1'b1);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("woken", r[`ASI_ST_RXF], 1);
		rd(`ASI_OFS_DATA, 2'b00);
		chk("wake_word", r, 32'h80);
		repeat (400) @(posedge MCLK);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("idle", r[`ASI_ST_IDLE], 1);
		wr(`ASI_OFS_CTRL1, 8'h00, 2'b00);
		rd(`ASI_OFS_DATA, 2'b00);
		wr(`ASI_OFS_CTRL2, 8'h0e, 2'b00);
		far.send(9'h033, 8, 1'b1);
		repeat (400) @(posedge MCLK);
		rd(`ASI_OFS_CTRL2, 2'b00);
		chk("quiet_wake", r[`ASI_C2_MUTE], 0);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("no_idle", r[`ASI_ST_IDLE], 0);
		far.send(9'h044, 8, 1'b1);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("full_again", r[`ASI_ST_RXF], 1);
		wr(`ASI_OFS_CTRL2, 8'h08, 2'b00);
		rd(`ASI_OFS_STATUS, 2'b00);
		chk("rx_off", r[`ASI_ST_RXF], 0);
	endtask
	task t_rate;
		int t0;
		wr(`ASI_OFS_CTRL2, 8'h00, 2'b00);
		@(posedge MCLK);
		chk("oe_off", TX_PIN_OE, 0);
		wr(`ASI_OFS_RATE, 8'h08, 2'b00);
		far.bit_len = 64;
		t0 = cycles;
		wr(`ASI_OFS_CTRL2, 8'h08, 2'b00);
		rd(`ASI_OFS_STATUS, 2'b00);
		wr(`ASI_OFS_DATA, 8'h96, 2'b00);
		far.grab(8, w, s);
		chk("rate_word", w, 9'h096);
		chk("idle_gap", cycles - t0 >= (10 + 9) * 64, 1);
	endtask
	task wrap_up;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up;
		end
	end
	initial begin
		RST = 1'b1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h0;
		CPU_IRQ_MASK = 1'b1;
		AWADDR = 8'h0;
		ARADDR = 8'h0;
		WDATA = 32'h0;
		WSTRB = 4'hf;
		repeat (6) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
		t_reset;
		t_tx;
		t_rx;
		t_mute;
		t_rate;
		wrap_up;
	end
endmodule // asi_top_tb_top
`default_nettype wire
